// File: logic/sdl_bit_loader.sv
`timescale 1ns/1ps
`include "sdl_defines.svh"

// Notes on behaviour
// - Bipolar codes offset binary; invert two's complement MSB.
// - Bipolar zero calibration loads top bit only.
// - Full scale calibration loads all ones.
// - Chain shares one data, clock, load line.
// - Each emulated write delivers the next bit.
// - Four MSBs first, then eight LSBs.
// - Serial bit taken from bus bit seven.
// - Shift strobe from decoded write and phase.
// - Separate load write copies input register.
// - Dedicated serial pin may replace bus bit.
// - Second strobe from address and write strobe.
// - Word right-justified in sixteen-bit pair.
// - Sixteen-bit bus shifts one bit per write.
module sdl_bit_loader
    import sdl_pkg::*;
#(
    parameter int CHAIN_LEN = 1,
    parameter int WORD_BITS = `SDL_WORD_BITS
) (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    // User side: one word per device, device 0 is the far end of the chain
    input  wire logic                    start_in,
    input  wire logic [CHAIN_LEN*16-1:0] words_in,
    input  wire sdl_pkg::sdl_fmt_type    fmt_in,
    input  wire logic                    zero_req_in,
    output logic                         busy_out,
    output logic                         done_out,
    // Converter chain pins
    output logic [7:0]                   bus_data_out,
    output logic                         fourth_shift_strobe_out,
    output logic                         load_strobe_a_n_out,
    output logic                         converter_register_zeroing_n_out
);
    import sdl_pkg::*;

    localparam int TOTAL = CHAIN_LEN * WORD_BITS;
    localparam int CW    = $clog2(TOTAL + 1);
    localparam int TW    = 8;

    // Refuse geometries the sequencer cannot serve
    if (CHAIN_LEN < 1) begin : g_chain_check
        $error("sdl_bit_loader: CHAIN_LEN must be at least 1");
    end
    if (WORD_BITS != `SDL_WORD_BITS) begin : g_word_check
        $error("sdl_bit_loader: word must be twelve bits");
    end

    typedef struct packed {
        sdl_state_type            st;
        logic [TOTAL-1:0]         shreg;
        logic [CW-1:0]            left;
        logic [7:0]               bus;
        logic                     stb;
        logic                     ld_n;
        logic                     clr_n;
        logic                     busy;
        logic                     done;
    } sdl_ctl_type;

    sdl_ctl_type st_r;
    sdl_ctl_type st_nxt;
    logic        tmr_start;
    logic [TW-1:0] tmr_count;
    logic        tmr_done;

    // Convert one stored 16-bit location pair to a 12-bit code
    function automatic logic [11:0] sdl_code(input logic [15:0] pair, input sdl_fmt_type f);
        logic [11:0] c;
        c = pair[11:0];
        case (f)
            SDL_FMT_TWOS:    c = {~pair[11], pair[10:0]};
            SDL_FMT_CAL_MID: c = `SDL_CODE_BIPOLAR_ZERO;
            SDL_FMT_CAL_FS:  c = `SDL_CODE_FULL_SCALE;
            default:         c = pair[11:0];
        endcase
        return c;
    endfunction

    sdl_pulse_timer #(
        .WIDTH (TW)
    ) u_timer (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .start_in (tmr_start),
        .count_in (tmr_count),
        .done_out (tmr_done)
    );

    // =================================================================
    // Sequencer
    // =================================================================
    always_comb begin
        st_nxt    = st_r;
        st_nxt.done = 1'b0;
        tmr_start = 1'b0;
        tmr_count = TW'(`SDL_STROBE_HIGH_CYC);
        // clear held low while requested, independent of shifting
        st_nxt.clr_n = ~zero_req_in;
        case (st_r.st)
            SDL_IDLE: begin
                if (start_in) begin
                    // each device word sent MSB first, far device first
                    for (int i = 0; i < CHAIN_LEN; i++) begin
                        st_nxt.shreg[TOTAL-1-i*WORD_BITS -: WORD_BITS] =
                            sdl_code(words_in[i*16 +: 16], fmt_in);
                    end
                    // bit on bus bit seven
                    // Data settles a cycle ahead of the strobe edge
                    st_nxt.bus  = {st_nxt.shreg[TOTAL-1], 7'h00};
                    st_nxt.left = CW'(TOTAL);
                    st_nxt.busy = 1'b1;
                    st_nxt.st   = SDL_SETUP;
                end
            end
            SDL_SETUP: begin
                st_nxt.stb = 1'b1;
                tmr_start  = 1'b1;
                st_nxt.st  = SDL_HIGH;
            end
            SDL_HIGH: begin
                if (tmr_done) begin
                    // strobe edge falls when the emulated write ends
                    st_nxt.stb   = 1'b0;
                    st_nxt.shreg = {st_r.shreg[TOTAL-2:0], 1'b0};
                    st_nxt.left  = st_r.left - CW'(1);
                    tmr_start    = 1'b1;
                    tmr_count    = TW'(`SDL_STROBE_LOW_CYC);
                    st_nxt.st    = SDL_LOW;
                end
            end
            SDL_LOW: begin
                if (tmr_done) begin
                    // load only after every chained bit is in
                    if (st_r.left == '0) begin
                        st_nxt.ld_n = 1'b0;
                        tmr_start   = 1'b1;
                        st_nxt.st   = SDL_LOAD;
                    end else begin
                        st_nxt.bus = {st_r.shreg[TOTAL-1], 7'h00};
                        st_nxt.st  = SDL_SETUP;
                    end
                end
            end
            SDL_LOAD: begin
                if (tmr_done) begin
                    st_nxt.ld_n = 1'b1;
                    st_nxt.busy = 1'b0;
                    st_nxt.done = 1'b1;
                    st_nxt.st   = SDL_IDLE;
                end
            end
            default: st_nxt.st = SDL_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r       <= '0;
            st_r.st    <= SDL_IDLE;
            st_r.ld_n  <= 1'b1;
            st_r.clr_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // four shared lines for the whole chain
    assign bus_data_out                     = st_r.bus;
    assign fourth_shift_strobe_out          = st_r.stb;
    assign load_strobe_a_n_out              = st_r.ld_n;
    assign converter_register_zeroing_n_out = st_r.clr_n;
    assign busy_out                         = st_r.busy;
    assign done_out                         = st_r.done;

    // =================================================================
    // Checks
    // =================================================================
    int unsigned fall_cnt;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fall_cnt <= 0;
        end else if (start_in && st_r.st == SDL_IDLE) begin
            fall_cnt <= 0;
        end else if (st_r.stb && !st_nxt.stb) begin
            fall_cnt <= fall_cnt + 1;
        end
    end

    a_load_after_bits: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $fell(load_strobe_a_n_out) |-> fall_cnt == TOTAL)
        else $error("load issued before all bits shifted");
    a_load_no_strobe: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !load_strobe_a_n_out |-> !fourth_shift_strobe_out)
        else $error("load and shift strobe overlap");
    a_bit_on_seven: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        bus_data_out[6:0] == 7'h00)
        else $error("data outside bus bit seven");
    a_bit_stable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        fourth_shift_strobe_out |-> $stable(bus_data_out))
        else $error("data changed while strobe high");
    a_strobe_width: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(fourth_shift_strobe_out) |-> fourth_shift_strobe_out [*5])
        else $error("shift strobe too short");
    a_load_ends: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $fell(load_strobe_a_n_out) |-> ##[5:8] load_strobe_a_n_out ##0 done_out)
        else $error("load pulse did not end with done");
    a_clear_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        zero_req_in |=> !converter_register_zeroing_n_out)
        else $error("clear not driven");
    a_first_msb: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_in && st_r.st == SDL_IDLE && fmt_in == SDL_FMT_CAL_FS) |-> ##3 bus_data_out[7])
        else $error("full scale first bit not one");
    a_mid_code: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_in && st_r.st == SDL_IDLE && fmt_in == SDL_FMT_CAL_MID) |=>
        st_r.shreg[TOTAL-1 -: WORD_BITS] == `SDL_CODE_BIPOLAR_ZERO)
        else $error("midscale code wrong");

    c_transfer: cover property (@(posedge clk_in) disable iff (!rst_n_in) done_out);
    c_clear: cover property (@(posedge clk_in) disable iff (!rst_n_in) $fell(converter_register_zeroing_n_out));
    c_twos: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        start_in && st_r.st == SDL_IDLE && fmt_in == SDL_FMT_TWOS);
endmodule

// File: logic/sdl_defines.svh
`ifndef SDL_DEFINES_SVH
`define SDL_DEFINES_SVH

// Word and chain geometry
`define SDL_WORD_BITS        12
`define SDL_BUS_BIT          7
`define SDL_HI_NIBBLE_BITS   4
// Calibration codes
`define SDL_CODE_BIPOLAR_ZERO 12'h800
`define SDL_CODE_FULL_SCALE   12'hFFF
`define SDL_CODE_ZERO         12'h000
// Strobe timing: high time and low time of the shift strobe; the load strobe low pulse reuses the high time
`define SDL_STROBE_HIGH_NS   40
`define SDL_STROBE_LOW_NS    40
`define SDL_CLK_PERIOD_NS    8
`define SDL_STROBE_HIGH_CYC  ((`SDL_STROBE_HIGH_NS + `SDL_CLK_PERIOD_NS - 1) / `SDL_CLK_PERIOD_NS)
`define SDL_STROBE_LOW_CYC   ((`SDL_STROBE_LOW_NS + `SDL_CLK_PERIOD_NS - 1) / `SDL_CLK_PERIOD_NS)

`endif

// File: logic/sdl_pkg.sv
package sdl_pkg;
    // Source format of the word handed in by the user
    typedef enum logic [1:0] {
        SDL_FMT_OFFSET  = 2'h0,
        SDL_FMT_TWOS    = 2'h1,
        SDL_FMT_CAL_MID = 2'h2,
        SDL_FMT_CAL_FS  = 2'h3
    } sdl_fmt_type;

    typedef enum logic [4:0] {
        SDL_IDLE  = 5'h01,
        SDL_SETUP = 5'h02,
        SDL_HIGH  = 5'h04,
        SDL_LOW   = 5'h08,
        SDL_LOAD  = 5'h10
    } sdl_state_type;
endpackage

// File: logic/sdl_pulse_timer.sv
`timescale 1ns/1ps
`include "sdl_defines.svh"

// Down counter giving a one-cycle done pulse after a loaded count
module sdl_pulse_timer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Control
    input  wire logic             start_in,
    input  wire logic [WIDTH-1:0] count_in,
    output logic                  done_out
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             run;
        logic             done;
    } sdl_tmr_type;

    sdl_tmr_type st_r;
    sdl_tmr_type st_nxt;

    if (WIDTH < 2) begin : g_width_check
        $error("sdl_pulse_timer: WIDTH too small");
    end

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (start_in) begin
            st_nxt.cnt = count_in;
            st_nxt.run = 1'b1;
        end else if (st_r.run) begin
            if (st_r.cnt <= WIDTH'(1)) begin
                st_nxt.run  = 1'b0;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done_out = st_r.done;

    // A load of five gives done on the sixth edge, the strobe phase length
    a_timer_len: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_in && count_in == WIDTH'(5)) |=> !done_out [*5] ##1 done_out)
        else $error("timer did not finish after six cycles");
endmodule

// File: sim/sdl_dac_chain_model.sv
`timescale 1ns/1ps

// ====================================================================
// Chain of serial-input converters as seen at the host pins
module sdl_dac_chain_model #(
    parameter int CHAIN_LEN = 1
) (
    // Shared host lines
    input  wire logic                    serial_bit_input_in,
    input  wire logic                    fourth_shift_strobe_in,
    input  wire logic                    load_strobe_a_n_in,
    input  wire logic                    converter_register_zeroing_n_in,
    // Observation
    output logic [CHAIN_LEN*12-1:0]      conv_out,
    output logic                         chained_bit_output_out
);
    logic [11:0] in_r [CHAIN_LEN];

    // one data, strobe and load line; MSB first; nearest device feeds the next
    always @(posedge fourth_shift_strobe_in) begin
        for (int d = 0; d < CHAIN_LEN; d++) begin
            in_r[d] <= {in_r[d][10:0], (d == CHAIN_LEN - 1) ? serial_bit_input_in : in_r[d+1][11]};
        end
    end

    assign chained_bit_output_out = in_r[0][11];

    // clear wins asynchronously; load is level sensitive, second load line tied low
    always @* begin
        for (int d = 0; d < CHAIN_LEN; d++) begin
            if (!converter_register_zeroing_n_in) begin
                conv_out[12*d+:12] = 12'h000;
            end else if (!load_strobe_a_n_in) begin
                conv_out[12*d+:12] = in_r[d];
            end
        end
    end
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps

module tb;
    import sdl_pkg::*;
    localparam int CL = 2;
    logic             clk_in      = 1'b0;
    logic             rst_n_in    = 1'b0;
    logic             start_in    = 1'b0;
    logic [CL*16-1:0] words_in    = '0;
    sdl_fmt_type      fmt_in      = SDL_FMT_OFFSET;
    logic             zero_req_in = 1'b0;
    logic             busy_out, done_out, strobe, load_n, clr_n, chain_out;
    logic [7:0]       bus_data_out;
    logic [CL*12-1:0] conv;
    logic             bitq[$];
    int               errors      = 0;
    int               num_checks  = 0;

    always #4 clk_in = ~clk_in;

    sdl_bit_loader #(.CHAIN_LEN(CL)) dut_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_in), .words_in(words_in),
        .fmt_in(fmt_in), .zero_req_in(zero_req_in), .busy_out(busy_out), .done_out(done_out),
        .bus_data_out(bus_data_out), .fourth_shift_strobe_out(strobe),
        .load_strobe_a_n_out(load_n), .converter_register_zeroing_n_out(clr_n));

    sdl_dac_chain_model #(.CHAIN_LEN(CL)) dev_u (
        .serial_bit_input_in(bus_data_out[7]), .fourth_shift_strobe_in(strobe),
        .load_strobe_a_n_in(load_n), .converter_register_zeroing_n_in(clr_n),
        .conv_out(conv), .chained_bit_output_out(chain_out));

    // ================================================================
    // Reporting
    task automatic finish_test();
        $display("Checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: code %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_num(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            errors++;
            $display("Error at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask

    // ================================================================
    // Reference model and pin monitors
    function automatic logic [11:0] exp_code(input int f, input int w);
        case (f)
            0: return w[11:0];
            1: return w[11:0] ^ 12'h800;
            2: return 12'h800;
            default: return 12'hFFF;
        endcase
    endfunction

    always @(posedge strobe) begin
        bitq.push_back(bus_data_out[7]);
        chk_code({5'h00, bus_data_out[6:0]}, 12'h000);
    end

    always @(negedge load_n) begin
        if (rst_n_in) chk_num(bitq.size(), 12 * CL);
    end

    // ================================================================
    // One word per device; poke tries a start that must be ignored
    task automatic run(input int f, input bit poke);
        int          w[CL];
        int          n;
        logic [11:0] e;
        bitq.delete();
        @(negedge clk_in);
        for (int i = 0; i < CL; i++) begin
            w[i] = $urandom % 4096;
            words_in[16*i+:16] = w[i][15:0];
        end
        fmt_in = sdl_fmt_type'(f);
        start_in = 1'b1;
        @(negedge clk_in);
        start_in = 1'b0;
        chk_bit(busy_out, 1'b1);
        n = 0;
        while (done_out !== 1'b1) begin
            @(negedge clk_in);
            n++;
            start_in = poke && n == 40;
            if (n == 40) words_in = words_in ^ {CL{16'h0FFF}};
            if (n > 2000) begin
                errors++;
                $display("Error at %0t: no completion", $time);
                finish_test();
            end
        end
        chk_bit(busy_out, 1'b0);
        for (int i = 0; i < CL; i++) begin
            e = exp_code(f, w[i]);
            for (int b = 11; b >= 0; b--) chk_bit(bitq[12*i+11-b], e[b]);
            chk_code(conv[12*i+:12], e);
            if (i == 0) chk_bit(chain_out, e[11]);
        end
        @(negedge clk_in);
        chk_bit(done_out, 1'b0);
    endtask

    initial begin
        void'($urandom(83843));
        repeat (12) @(posedge clk_in);
        @(negedge clk_in);
        rst_n_in = 1'b1;
        for (int f = 0; f < 4; f++) run(f, f == 1);
        @(negedge clk_in);
        zero_req_in = 1'b1;
        repeat (3) @(negedge clk_in);
        chk_bit(clr_n, 1'b0);
        for (int i = 0; i < CL; i++) chk_code(conv[12*i+:12], 12'h000);
        zero_req_in = 1'b0;
        repeat (3) @(negedge clk_in);
        chk_code(conv[11:0], 12'h000);
        for (int k = 0; k < 6; k++) run(int'($urandom % 4), 1'b0);
        finish_test();
    end
endmodule
